/* core/boot_mode_select.sv */
// The implementer's own choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ns
`include "boot_select_regs.svh"
// boot decision logic with flash op timer, ahb-lite register slave
module boot_mode_select #(
  parameter int SETTLE_CYC = `SETTLE_CYC,
  parameter int ERASE_CYC = `ERASE_CYC,
  parameter int PROG_CYC = `PROG_CYC,
  parameter logic [31:0] DISABLE_CODE = 32'h4E4F_5049,
  parameter logic [7:0] BOOT_VER = `VER_RESET
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // straps and boot inputs
  input wire logic prog_entry_pin,
  input wire logic iface_select_pin,
  input wire logic wdt_ovf_flag,
  input wire logic power_down,
  // flash read port
  output logic flash_rd_req,
  output logic [31:0] flash_rd_addr,
  input wire logic [31:0] flash_rd_data,
  input wire logic flash_rd_ack,
  // boot results
  output logic boot_done,
  output logic boot_user,
  output logic boot_usb,
  output logic boot_uart,
  output logic uart_rx_pin_en,
  output logic uart_tx_pin_en,
  output logic flash_busy,
  output logic sram_retain
);
  import boot_select_pkg::*;

  // ****************************************************************
  // declarations
  // ****************************************************************
  boot_state_type state_reg; // sequencer state
  logic [21:0] cnt_reg; // settle counter
  logic entry_reg; // sampled entry strap
  logic select_reg; // sampled select strap
  logic wdt_reg; // sampled watchdog flag
  logic pin_dis_reg; // disable word found
  logic checked_reg; // vector check was run
  logic [3:0] word_reg; // vector word index
  logic rd_req_reg; // flash read pending
  logic [31:0] rd_addr_reg; // flash read address
  logic user_reg; // run user code
  logic usb_reg; // mass storage boot
  logic uart_reg; // uart programming boot
  logic sum_clr; // clear accumulator
  logic sum_add; // add a vector word
  logic [31:0] sum_val; // running sum
  logic sum_zero; // sum equals zero
  logic uart_only; // loader ignores select pin
  flash_op_type op_reg; // running flash op
  logic [21:0] op_cnt_reg; // flash op counter
  logic [21:0] op_len; // length of running op
  logic acc_ph; // address phase accepted
  logic wr_pend_reg; // write data phase pending
  logic [7:0] wr_ofs_reg; // write offset
  logic [31:0] rdata_reg; // read data register
  logic [31:0] stat_word; // status view

  // ****************************************************************
  // boot sequencer
  // ****************************************************************
  // the loader with minor 1 only has uart booting
  assign uart_only = (BOOT_VER == `VER_UART_ONLY); // R10

  // sequencer: disable word, settle, sample, check, pick
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ST_DISRD;
    end else if (ce) begin
      unique case (state_reg)
        // wait for the disable word
        ST_DISRD: begin
          if (flash_rd_ack) begin
            state_reg <= ST_SETTLE;
          end
        end
        // wait out the settle time
        ST_SETTLE: begin
          if (cnt_reg == 22'(SETTLE_CYC - 1)) begin
            state_reg <= ST_SAMPLE; // R2
          end
        end
        // choose between check and direct programming
        ST_SAMPLE: begin
          if (wdt_reg) begin
            state_reg <= ST_SUM; // R3
          end else if (!entry_reg && !pin_dis_reg) begin
            state_reg <= ST_PICK; // R1
          end else begin
            state_reg <= ST_SUM; // R4 R8
          end
        end
        // read the vector words
        ST_SUM: begin
          if (flash_rd_ack && word_reg == `VECTOR_WORDS - 4'h1) begin
            state_reg <= ST_PICK;
          end
        end
        ST_PICK: begin
          state_reg <= ST_DONE;
        end
        // hold until the next reset
        ST_DONE: begin
          state_reg <= ST_DONE;
        end
        default: begin
          state_reg <= ST_DISRD;
        end
      endcase
    end
  end

  // settle counter, runs in the settle state only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= '0;
    end else if (ce && state_reg == ST_SETTLE) begin
      cnt_reg <= cnt_reg + 22'h1;
    end
  end

  // disable word compare
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_dis_reg <= 1'b0;
    end else if (ce && state_reg == ST_DISRD && flash_rd_ack) begin
      pin_dis_reg <= (flash_rd_data == DISABLE_CODE); // R8
    end
  end

  // straps taken once at the end of settling, then held
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      entry_reg <= 1'b1;
      select_reg <= 1'b0;
      wdt_reg <= 1'b0;
    end else if (ce && state_reg == ST_SETTLE &&
                 cnt_reg == 22'(SETTLE_CYC - 1)) begin
      entry_reg <= prog_entry_pin; // R15
      select_reg <= iface_select_pin; // R15
      wdt_reg <= wdt_ovf_flag;
    end
  end

  // flash read requests: disable word first, then vectors
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_req_reg <= 1'b1;
      rd_addr_reg <= `DISABLE_WORD_ADDR;
      word_reg <= 4'h0;
    end else if (ce) begin
      if (flash_rd_ack) begin
        // each ack ends one read
        rd_req_reg <= state_reg == ST_SUM &&
                      word_reg != `VECTOR_WORDS - 4'h1;
        rd_addr_reg <= `VECTOR_BASE_ADDR + {26'h0, word_reg + 4'h1, 2'h0};
        word_reg <= (state_reg == ST_SUM) ? word_reg + 4'h1 : 4'h0;
      end else if (state_reg == ST_SAMPLE &&
                   (wdt_reg || entry_reg || pin_dis_reg)) begin
        // start the vector scan
        rd_req_reg <= 1'b1;
        rd_addr_reg <= `VECTOR_BASE_ADDR;
        word_reg <= 4'h0;
      end
    end
  end

  // mark whether the vector check was run
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      checked_reg <= 1'b0;
    end else if (ce && state_reg == ST_SUM && flash_rd_ack &&
                 word_reg == `VECTOR_WORDS - 4'h1) begin
      checked_reg <= 1'b1;
    end
  end

  assign sum_clr = (state_reg == ST_SAMPLE);
  assign sum_add = (state_reg == ST_SUM) && flash_rd_ack;

  // vector sum over the eight words
  check_sum_acc #(.WIDTH(32)) u_sum (
    .clk(hclk),
    .rst_n(hresetn),
    .ce(ce),
    .clr(sum_clr),
    .add(sum_add),
    .data(flash_rd_data),
    .sum(sum_val),
    .zero(sum_zero)
  );

  // boot target, decided once
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      user_reg <= 1'b0;
      usb_reg <= 1'b0;
      uart_reg <= 1'b0;
    end else if (ce && state_reg == ST_PICK) begin
      if (checked_reg && sum_zero) begin
        user_reg <= 1'b1; // R5 R14
      end else if (select_reg && !uart_only) begin
        usb_reg <= 1'b1; // R6
      end else begin
        uart_reg <= 1'b1; // R7 R9 R10
      end
    end
  end

  // ****************************************************************
  // flash op timer
  // ****************************************************************
  assign op_len = (op_reg == OP_ERASE) ? 22'(ERASE_CYC) : 22'(PROG_CYC);

  // erase or block program runs for its nominal time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      op_reg <= OP_IDLE;
      op_cnt_reg <= '0;
    end else if (ce) begin
      if (op_reg != OP_IDLE) begin
        if (op_cnt_reg == op_len - 22'h1) begin
          op_reg <= OP_IDLE; // R11
          op_cnt_reg <= '0;
        end else begin
          op_cnt_reg <= op_cnt_reg + 22'h1;
        end
      end else if (wr_pend_reg && wr_ofs_reg == `CTRL_OFS && boot_done) begin
        // erase wins when both are written
        if (hwdata[`CTRL_ERASE_BIT]) begin
          op_reg <= OP_ERASE;
        end else if (hwdata[`CTRL_PROG_BIT]) begin
          op_reg <= OP_PROG;
        end
      end
    end
  end

  // ****************************************************************
  // ahb-lite slave
  // ****************************************************************
  assign acc_ph = hsel && htrans[1] && hready;

  // address phase capture for writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_ofs_reg <= 8'h00;
    end else if (ce) begin
      wr_pend_reg <= acc_ph && hwrite;
      wr_ofs_reg <= haddr[7:0];
    end
  end

  // status view of the sequencer
  always_comb begin
    stat_word = 32'h0000_0000;
    stat_word[`STAT_DONE_BIT] = boot_done;
    stat_word[`STAT_USER_BIT] = user_reg;
    stat_word[`STAT_USB_BIT] = usb_reg;
    stat_word[`STAT_UART_BIT] = uart_reg;
    stat_word[`STAT_ENTRY_BIT] = entry_reg;
    stat_word[`STAT_SELECT_BIT] = select_reg;
    stat_word[`STAT_WDT_BIT] = wdt_reg;
    stat_word[`STAT_PINDIS_BIT] = pin_dis_reg;
    stat_word[`STAT_VALID_BIT] = checked_reg && sum_zero;
    stat_word[`STAT_BUSY_BIT] = flash_busy;
  end

  // read data loaded at address phase, shown in data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_reg <= 32'h0000_0000;
    end else if (ce && acc_ph && !hwrite) begin
      // unmapped offsets read zero
      unique case (haddr[7:0])
        `STAT_OFS: rdata_reg <= stat_word;
        `VER_OFS: rdata_reg <= {24'h000000, BOOT_VER};
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  assign hrdata = rdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign boot_done = (state_reg == ST_DONE);
  assign boot_user = user_reg;
  assign boot_usb = usb_reg;
  assign boot_uart = uart_reg;
  assign uart_rx_pin_en = uart_reg; // R7
  assign uart_tx_pin_en = uart_reg; // R7
  assign flash_busy = (op_reg != OP_IDLE);
  assign flash_rd_req = rd_req_reg;
  // reads stay in flash, the low sram range is never addressed
  assign flash_rd_addr = rd_addr_reg; // R12
  // sram contents lost once power goes down
  assign sram_retain = !power_down; // R13

  // ****************************************************************
  // checks
  // ****************************************************************
  a_entry_skip: assert property (@(posedge hclk) disable iff (!hresetn) // R1
    boot_done && !wdt_reg && !entry_reg && !pin_dis_reg |-> !checked_reg)
    else $error("check ran despite programming request");

  a_settle_sample: assert property (@(posedge hclk) // R2
    disable iff (!hresetn)
    ce && state_reg == ST_SAMPLE |-> $past(cnt_reg) == 22'(SETTLE_CYC - 1))
    else $error("straps sampled before settling ended");

  a_wdt_check: assert property (@(posedge hclk) disable iff (!hresetn) // R3
    boot_done && wdt_reg |-> checked_reg)
    else $error("watchdog boot skipped the check");

  a_high_search: assert property (@(posedge hclk) disable iff (!hresetn) // R4
    boot_done && entry_reg |-> checked_reg)
    else $error("no search with entry pin high");

  a_valid_user: assert property (@(posedge hclk) disable iff (!hresetn) // R5
    ce && state_reg == ST_PICK && checked_reg && sum_zero
    |=> boot_user && !boot_usb && !boot_uart)
    else $error("valid code did not run");

  a_select_usb: assert property (@(posedge hclk) disable iff (!hresetn) // R6
    boot_done && !boot_user && select_reg && !uart_only |-> boot_usb)
    else $error("select high did not pick usb");

  a_select_uart: assert property (@(posedge hclk) disable iff (!hresetn) // R7
    boot_done && !boot_user && (!select_reg || uart_only)
    |-> boot_uart && uart_rx_pin_en && uart_tx_pin_en)
    else $error("uart boot not set up");

  a_pin_disable: assert property (@(posedge hclk) disable iff (!hresetn) // R8
    boot_done && pin_dis_reg |-> checked_reg)
    else $error("disabled entry pin was honoured");

  a_op_length: assert property (@(posedge hclk) disable iff (!hresetn) // R11
    ce && flash_busy && op_cnt_reg == op_len - 22'h1 |=> !flash_busy)
    else $error("flash op did not end on time");

  a_strap_hold: assert property (@(posedge hclk) disable iff (!hresetn) // R15
    state_reg inside {ST_SUM, ST_PICK, ST_DONE}
    |=> $stable(entry_reg) && $stable(select_reg))
    else $error("strap value changed after sampling");
endmodule // boot_mode_select

/* core/boot_select_regs.svh */
// Overview of operation
// R1: low entry pin requests programming, skips check
// R2: sample entry pin up to 3 ms
// R3: watchdog flag set goes straight to check
// R4: entry pin high searches for user code
// R5: valid code runs, else read select pin
// R6: select pin high enumerates as mass storage
// R7: select pin low starts uart programming
// R8: disable word stops entry pin sampling
// R9: later loaders need both pins low
// R10: loader 7.1 needs entry pin only
// R11: sector erase 100 ms, block 1 ms
// R12: lowest sram range is never touched
// R13: sram not kept through power down
// R14: code valid when eight vectors sum zero
// R15: straps sampled once, held until decided
`ifndef BOOT_SELECT_REGS_SVH
`define BOOT_SELECT_REGS_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define CTRL_OFS 8'h00
`define STAT_OFS 8'h04
`define VER_OFS 8'h08

// ****************************************************************
// field positions
// ****************************************************************
`define CTRL_ERASE_BIT 0
`define CTRL_PROG_BIT 1
`define STAT_DONE_BIT 0
`define STAT_USER_BIT 1
`define STAT_USB_BIT 2
`define STAT_UART_BIT 3
`define STAT_ENTRY_BIT 4
`define STAT_SELECT_BIT 5
`define STAT_WDT_BIT 6
`define STAT_PINDIS_BIT 7
`define STAT_VALID_BIT 8
`define STAT_BUSY_BIT 9

// ****************************************************************
// flash locations and loader values
// ****************************************************************
`define DISABLE_WORD_ADDR 32'h0000_02FC
`define VECTOR_BASE_ADDR 32'h0000_0000
`define VECTOR_WORDS 4'h8
`define VER_UART_ONLY 8'h71
`define VER_RESET 8'h74
`define SRAM_KEEP_LO 32'h1000_0000
`define SRAM_KEEP_HI 32'h1000_0050

// ****************************************************************
// timing
// ****************************************************************
`define CLK_KHZ 10000
`define SETTLE_TIME_US 3000
`define ERASE_TIME_US 100000
`define PROG_TIME_US 1000
`define SETTLE_CYC (`SETTLE_TIME_US * `CLK_KHZ / 1000)
`define ERASE_CYC (`ERASE_TIME_US * `CLK_KHZ / 1000)
`define PROG_CYC (`PROG_TIME_US * `CLK_KHZ / 1000)

`endif

/* core/boot_select_pkg.sv */
package boot_select_pkg;
  // boot sequencer states
  typedef enum logic [2:0] {
    ST_DISRD = 3'h0,
    ST_SETTLE = 3'h1,
    ST_SAMPLE = 3'h2,
    ST_SUM = 3'h3,
    ST_PICK = 3'h4,
    ST_DONE = 3'h5
  } boot_state_type;
  // flash timed operations
  typedef enum logic [1:0] {
    OP_IDLE = 2'h0,
    OP_ERASE = 2'h1,
    OP_PROG = 2'h2
  } flash_op_type;
endpackage

/* core/check_sum_acc.sv */
`timescale 1ns/1ns
// running word sum used for the vector check
module check_sum_acc #(
  parameter int WIDTH = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic clr,
  input wire logic add,
  input wire logic [WIDTH-1:0] data,
  output logic [WIDTH-1:0] sum,
  output logic zero
);
  // ****************************************************************
  // accumulator
  // ****************************************************************
  // clear wins over add, sum wraps modulo two to the width
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sum <= '0;
    end else if (ce) begin
      if (clr) begin
        sum <= '0;
      end else if (add) begin
        sum <= sum + data; // R14
      end
    end
  end

  assign zero = (sum == '0);

  a_sum_add: assert property (@(posedge clk) disable iff (!rst_n) // R14
    ce && add && !clr |=> sum == $past(sum) + $past(data))
    else $error("sum did not add the word");
endmodule // check_sum_acc

/* test/flash_model.sv */
`timescale 1ns/1ns
// ****************************************************************
// flash read responder, latency set by the bench
// ****************************************************************
module flash_model #(
  parameter logic [31:0] DISABLE_CODE = 32'h4E4F_5049 // arbitrary
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic rd_req,
  input wire logic [31:0] rd_addr,
  input wire logic code_ok,
  input wire logic disable_on,
  input wire logic [3:0] lat,
  output logic [31:0] rd_data,
  output logic rd_ack
);
  logic [3:0] wait_cnt; // idle cycles spent on this read
  // stored word at a byte address
  function automatic logic [31:0] word_at(input logic [31:0] a);
    logic [31:0] sum;
    sum = 32'h0;
    if (a == 32'h0000_02FC) begin
      return disable_on ? DISABLE_CODE : 32'hFFFF_FFFF;
    end
    for (int i = 0; i < 7; i++) begin
      sum = sum + 32'h0123_4567 * 32'(i + 1);
    end
    if (a[4:2] != 3'h7) begin
      return 32'h0123_4567 * 32'(a[4:2] + 3'h1);
    end
    return (32'h0 - sum) + {31'h0, ~code_ok};
  endfunction
  // answer one read after lat idle cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_cnt <= 4'h0;
      rd_ack <= 1'b0;
      rd_data <= 32'h0;
    end else if (rd_ack) begin
      rd_ack <= 1'b0;
      rd_data <= ~rd_data; // released lines show no stale word
    end else if (rd_req && wait_cnt == lat) begin
      rd_ack <= 1'b1;
      rd_data <= word_at(rd_addr);
      wait_cnt <= 4'h0;
    end else if (rd_req) begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule // flash_model

/* test/boot_mode_select_tb.sv */
`timescale 1ns/1ns
`include "boot_select_regs.svh"
module boot_mode_select_tb;
  import boot_select_pkg::*;
  localparam int SETTLE = 20; // shortened settle count
  localparam int ERASE = 50; // shortened erase count
  localparam int PROG = 10; // shortened program count
  localparam int LIMIT = 6000; // cycle ceiling for the run
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic ce = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic prog_entry_pin = 1'b1;
  logic iface_select_pin = 1'b0;
  logic wdt_ovf_flag = 1'b0;
  logic power_down = 1'b0;
  logic code_ok = 1'b1;
  logic disable_on = 1'b0;
  logic [3:0] lat = 4'h0;
  logic [31:0] hrdata, flash_rd_addr, flash_rd_data;
  logic hreadyout, hresp, flash_rd_req, flash_rd_ack;
  logic boot_done, boot_user, boot_usb, boot_uart;
  logic uart_rx_pin_en, uart_tx_pin_en, flash_busy, sram_retain;
  logic alt_done, alt_usb, alt_uart; // uart-only loader results
  int n_mismatch = 0; // failed comparisons
  int compares = 0; // comparisons made
  int cyc = 0; // cycles since start
  int busy_cnt = 0; // cycles seen with flash busy
  logic [31:0] rd;
  // ****************************************************************
  // clock, units and watchdog of the run
  // ****************************************************************
  always #50 hclk = ~hclk;
  boot_mode_select #(.SETTLE_CYC(SETTLE), .ERASE_CYC(ERASE),
    .PROG_CYC(PROG)) i_dut (.hclk(hclk), .hresetn(hresetn), .ce(ce),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .prog_entry_pin(prog_entry_pin), .iface_select_pin(iface_select_pin),
    .wdt_ovf_flag(wdt_ovf_flag), .power_down(power_down),
    .flash_rd_req(flash_rd_req), .flash_rd_addr(flash_rd_addr),
    .flash_rd_data(flash_rd_data), .flash_rd_ack(flash_rd_ack),
    .boot_done(boot_done), .boot_user(boot_user), .boot_usb(boot_usb),
    .boot_uart(boot_uart), .uart_rx_pin_en(uart_rx_pin_en),
    .uart_tx_pin_en(uart_tx_pin_en), .flash_busy(flash_busy),
    .sram_retain(sram_retain));
  flash_model i_flash (.clk(hclk), .rst_n(hresetn), .rd_req(flash_rd_req),
    .rd_addr(flash_rd_addr), .code_ok(code_ok), .disable_on(disable_on),
    .lat(lat), .rd_data(flash_rd_data), .rd_ack(flash_rd_ack));
  // second unit on a uart-only loader, fed by the same flash answers
  boot_mode_select #(.SETTLE_CYC(SETTLE), .ERASE_CYC(ERASE),
    .PROG_CYC(PROG), .BOOT_VER(`VER_UART_ONLY)) i_dut_alt (.hclk(hclk),
    .hresetn(hresetn), .ce(ce), .hsel(1'b0), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(), .hreadyout(), .hresp(),
    .prog_entry_pin(prog_entry_pin), .iface_select_pin(iface_select_pin),
    .wdt_ovf_flag(wdt_ovf_flag), .power_down(power_down),
    .flash_rd_req(), .flash_rd_addr(), .flash_rd_data(flash_rd_data),
    .flash_rd_ack(flash_rd_ack), .boot_done(alt_done),
    .boot_user(), .boot_usb(alt_usb), .boot_uart(alt_uart),
    .uart_rx_pin_en(), .uart_tx_pin_en(), .flash_busy(),
    .sram_retain());
  // busy length counter and hang guard
  always @(posedge hclk) begin
    cyc++;
    if (flash_busy === 1'b1) begin
      busy_cnt <= busy_cnt + 1;
    end
    // flash reads never reach the kept sram range
    if (flash_rd_req === 1'b1) begin
      check("sram_keep", {31'h0, flash_rd_addr >= `SRAM_KEEP_LO &&
        flash_rd_addr <= `SRAM_KEEP_HI}, 32'h0);
    end
    if (cyc == LIMIT) begin
      n_mismatch++;
      end_of_test();
    end
  end
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  // verdict and end of run
  task automatic end_of_test();
    if (n_mismatch == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // compare one value
  task automatic check(input string name, input logic [31:0] got,
    input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  // one single word transfer on the register bus
  task automatic ahb_xfer(input logic wr, input logic [31:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  // reset with given straps {entry,sel,wdt,ok,dis,slow}, check choice
  task automatic boot(input logic [5:0] c);
    int n;
    logic user, uart, scan;
    @(posedge hclk);
    hresetn <= 1'b0;
    prog_entry_pin <= c[5];
    iface_select_pin <= c[4];
    wdt_ovf_flag <= c[3];
    code_ok <= c[2];
    disable_on <= c[1];
    lat <= c[0] ? 4'h3 : 4'h0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    n = 0;
    while (boot_done !== 1'b1 && n < 400) begin
      @(negedge hclk);
      n++;
    end
    scan = c[5] | c[3] | c[1];
    user = scan & c[2];
    uart = ~c[4] & ~user;
    check("time_low", 32'(n >= SETTLE), 32'h1);
    check("time_high", 32'(n <= SETTLE + 9 * (c[0] ? 5 : 2) + 4), 32'h1);
    for (int r = 0; r < 2; r++) begin
      check("outputs", {26'h0, boot_done, boot_user, boot_usb, boot_uart,
        uart_rx_pin_en, uart_tx_pin_en},
        {26'h0, 1'b1, user, ~uart & ~user, uart, uart, uart});
      check("uart_only", {29'h0, alt_done, alt_usb, alt_uart},
        {29'h0, 1'b1, 1'b0, ~user});
      ahb_xfer(1'b0, 32'(`STAT_OFS), 32'h0, rd);
      check("status", rd, {23'h0, scan & c[2], c[1], c[3], c[4], c[5],
        uart, ~uart & ~user, user, 1'b1});
      prog_entry_pin <= ~c[5];
      iface_select_pin <= ~c[4];
      wdt_ovf_flag <= ~c[3];
      repeat (3) @(posedge hclk);
    end
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  logic [5:0] cases [9] = '{
    6'b010100,
    6'b000101,
    6'b100100,
    6'b110001,
    6'b100000,
    6'b011101,
    6'b001000,
    6'b010111,
    6'b010010
  };
  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    // nine chosen strap and content combinations
    foreach (cases[i]) begin
      boot(cases[i]);
    end
    // register map reads
    ahb_xfer(1'b0, 32'(`CTRL_OFS), 32'h0, rd);
    check("ctrl_read", rd, 32'h0);
    ahb_xfer(1'b0, 32'(`VER_OFS), 32'h0, rd);
    check("version", rd, {24'h0, `VER_RESET});
    ahb_xfer(1'b0, 32'h0C, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    check("resp", {31'h0, hresp}, 32'h0);
    // timed flash operations, both bits means erase
    for (int k = 1; k < 4; k++) begin
      busy_cnt = 0;
      ahb_xfer(1'b1, 32'(`CTRL_OFS), 32'(k), rd);
      ahb_xfer(1'b0, 32'(`STAT_OFS), 32'h0, rd);
      check("busy_flag", {31'h0, rd[`STAT_BUSY_BIT]}, 32'h1);
      ahb_xfer(1'b1, 32'(`CTRL_OFS), 32'h2, rd);
      // last erase: freeze the timer for five edges
      if (k == 3) begin
        ce <= 1'b0;
        repeat (5) @(posedge hclk);
        ce <= 1'b1;
      end
      while (flash_busy === 1'b1 && busy_cnt < 200) @(negedge hclk);
      check("busy_len", 32'(busy_cnt),
        32'(k == 2 ? PROG : ERASE + (k == 3 ? 5 : 0)));
    end
    // power loss drops retention
    @(posedge hclk);
    power_down <= 1'b1;
    @(negedge hclk);
    check("retain_off", {31'h0, sram_retain}, 32'h0);
    @(posedge hclk);
    power_down <= 1'b0;
    @(negedge hclk);
    check("retain_on", {31'h0, sram_retain}, 32'h1);
    end_of_test();
  end
endmodule // boot_mode_select_tb
